// [logic/failsafe_params.svh]
// Purpose: offsets, field positions, reset values and timing counts of the fail-safe power control
// Assumes: 100 MHz system clock
// Notes: every time figure is kept in its own unit and converted to cycles here
`ifndef FAILSAFE_PARAMS_SVH
`define FAILSAFE_PARAMS_SVH

// clock rate
`define CLK_MHZ 100

// register byte offsets
`define OFS_STATUS 8'h00
`define OFS_FLAGS 8'h04
`define OFS_COUNT 8'h08
`define OFS_CONFIG 8'h0c

// status fields
`define STS_STATE_LSB 0
`define STS_OVDET_BIT 8
`define STS_FUSE_LOADED_BIT 9

// failure flag positions
`define FLG_POWERUP 0
`define FLG_WATCHDOG 1
`define FLG_REGULATOR 2
`define FLG_THERMAL 3

// config fields
`define CFG_LIMIT_LSB 0
`define CFG_BYPASS_BIT 4
`define CFG_DECAY_LSB 5
`define CFG_OVEN_BIT 8
`define CFG_OVSD_BIT 9
`define CFG_DBNC_LSB 10

// reset values and count ceiling
`define RST_COUNT 4'h0
`define RST_FLAGS 4'h0
`define COUNT_MAX 4'hf

// overvoltage debounce times in us and their cycle counts
`define OV_DBNC0_US 10
`define OV_DBNC1_US 100
`define OV_DBNC2_US 1000
`define OV_DBNC0_CYC (`OV_DBNC0_US * `CLK_MHZ)
`define OV_DBNC1_CYC (`OV_DBNC1_US * `CLK_MHZ)
`define OV_DBNC2_CYC (`OV_DBNC2_US * `CLK_MHZ)

// startup bound from threshold crossing to first slot, in us and cycles (rounded down)
`define STARTUP_MAX_US 1500
`define STARTUP_MAX_CYC (`STARTUP_MAX_US * `CLK_MHZ)

// decay timer base: one minute
`define MINUTE_S 60
`define MINUTE_CYC (64'd60 * 64'd1000000 * `CLK_MHZ)

`endif

// [logic/failsafe_pkg.sv]
// Purpose: types of the fail-safe power control
// Assumes: nothing
// Notes: states are one-hot
package failsafe_pkg;

  typedef enum logic [7:0] {
    ST_UNPWR = 8'h01,
    ST_LOAD = 8'h02,
    ST_OFF = 8'h04,
    ST_PWRUP = 8'h08,
    ST_ON = 8'h10,
    ST_PWRDN = 8'h20,
    ST_FSTRANS = 8'h40,
    ST_LOCK = 8'h80
  } pstate_e;

  typedef struct packed {
    logic [39:0] pre;
    logic [5:0] mins;
    logic tick;
  } decay_s;

endpackage

// [logic/decay_timer.sv]
// Purpose: fail-safe OK timer, pulses once per selected decay period
// Assumes: run is a same-clock level
// Notes: timing restarts whenever run drops
`timescale 1ns/1ns
`default_nettype none
`include "failsafe_params.svh"
module decay_timer
  import failsafe_pkg::*;
#(
  parameter longint unsigned CYC_PER_MIN = `MINUTE_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [2:0] period_sel,
  output logic tick
);

  decay_s s_q;
  decay_s s_d;

  // period table in minutes
  function automatic logic [5:0] period_min(input logic [2:0] sel);
    case (sel)
      3'h0: period_min = 6'h01;
      3'h1: period_min = 6'h05;
      3'h2: period_min = 6'h0a;
      3'h3: period_min = 6'h0f;
      3'h4: period_min = 6'h14;
      3'h5: period_min = 6'h1e;
      3'h6: period_min = 6'h2d;
      default: period_min = 6'h3c;
    endcase
  endfunction

  // minute prescaler then minute counter
  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!run)
    begin
      s_d.pre = 40'h0;
      s_d.mins = 6'h0;
    end
    else if (s_q.pre == 40'(CYC_PER_MIN - 64'd1))
    begin
      s_d.pre = 40'h0;
      if (s_q.mins + 6'h1 >= period_min(period_sel))
      begin
        s_d.mins = 6'h0;
        s_d.tick = 1'b1;
      end
      else
      begin
        s_d.mins = s_q.mins + 6'h1;
      end
    end
    else
    begin
      s_d.pre = s_q.pre + 40'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tick = s_q.tick;

endmodule
`default_nettype wire

// [logic/failsafe_powerdown_control.sv]
// Purpose: power state control with fail-safe counting, lock-down and input overvoltage handling
// Assumes: sequencers, watchdog and fault monitors are same-clock logic; pins are synchronised here
// Notes: registers on AHB-Lite, zero wait states
// Behaviour
// - power-down disables all but retention supply
// - clean turn-off goes to low power off
// - fault turn-off goes to fail-safe transition
// - fault sets one of four source flags
// - flags held while input above threshold
// - host reads flags, write one clears
// - fail-safe entry compares then increments count
// - lock-down when count equals limit
// - bypass fuse always returns to off
// - limit from fuse, zero locks immediately
// - lock-down left only by power cycle
// - decay timer decrements count during on
// - decay period chosen by three-bit fuse
// - host may clear count during on
// - fuses loaded only after threshold crossing
// - overvoltage interrupts or powers down by select
// - monitor enable and select default from fuses
// - overvoltage during power-up aborts when selected
// - debounce chosen by two-bit field
// - power-up starts within 1.5 ms
// - equal turn-on timing in level, edge modes
// - watchdog max count powers down to fail-safe
//
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "failsafe_params.svh"
module failsafe_powerdown_control
  import failsafe_pkg::*;
#(
  parameter int DBNC0_CYC = `OV_DBNC0_CYC,
  parameter int DBNC1_CYC = `OV_DBNC1_CYC,
  parameter int DBNC2_CYC = `OV_DBNC2_CYC,
  parameter longint unsigned CYC_PER_MIN = `MINUTE_CYC
)
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic UV_ABOVE,
  input wire logic OV_COMPARE,
  input wire logic POWER_ON_REQUEST,
  input wire logic [3:0] FUSE_LIMIT,
  input wire logic FUSE_BYPASS,
  input wire logic [2:0] FUSE_DECAY,
  input wire logic FUSE_OV_MONITOR,
  input wire logic FUSE_OV_SHUTDOWN,
  input wire logic [1:0] FUSE_OV_DEBOUNCE,
  input wire logic FUSE_EDGE_SELECT,
  input wire logic OFF_REQUEST,
  input wire logic POWERUP_FAIL_FLAG_EVENT,
  input wire logic WD_MAXED_EVENT,
  input wire logic REG_FAIL_EVENT,
  input wire logic THERMAL_EVENT,
  input wire logic PU_SEQ_DONE,
  input wire logic PD_SEQ_DONE,
  output logic PU_SEQ_START,
  output logic PU_SEQ_ABORT,
  output logic PD_SEQ_START,
  output logic REGS_PERMIT,
  output logic RETENTION_ON,
  output logic OV_INTERRUPT,
  output logic [7:0] STATE,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    pstate_e st;
    logic [1:0] uv_s;
    logic [1:0] ov_s;
    logic [1:0] pon_s;
    logic pon_prev;
    logic fault;
    logic [3:0] flags;
    logic [3:0] failsafe_event_count;
    logic [3:0] fs_lim;
    logic bypass;
    logic [2:0] decay_sel;
    logic ov_en;
    logic ov_sdwn;
    logic [1:0] dbnc;
    logic edge_mode;
    logic [19:0] dbnc_cnt;
    logic ov_det;
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
    logic pu_start;
    logic pu_abort;
    logic pd_start;
    logic regs_permit;
    logic retain_on;
    logic ov_irq;
  } ctl_s;

  ctl_s s_q;
  ctl_s s_d;
  logic decay_tick;
  logic ov_evt;
  logic pon_evt;
  logic host_wr;

  // debounce length for the selected field; reserved code keeps the longest
  function automatic logic [19:0] dbnc_len(input logic [1:0] sel);
    case (sel)
      2'h0: dbnc_len = 20'(DBNC0_CYC);
      2'h1: dbnc_len = 20'(DBNC1_CYC);
      default: dbnc_len = 20'(DBNC2_CYC);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decay timer runs only in system-on with a nonzero count

  decay_timer #(
    .CYC_PER_MIN(CYC_PER_MIN)
  ) u_decay (
    .clk(CLK_SYS),
    .rst(RST),
    .run((s_q.st == ST_ON) && (s_q.failsafe_event_count != 4'h0)),
    .period_sel(s_q.decay_sel),
    .tick(decay_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb
  begin
    s_d = s_q;
    ov_evt = 1'b0;
    pon_evt = 1'b0;
    host_wr = 1'b0;
    // pins pass two flops; only the second stage is read below
    s_d.uv_s = {s_q.uv_s[0], UV_ABOVE};
    s_d.ov_s = {s_q.ov_s[0], OV_COMPARE};
    s_d.pon_s = {s_q.pon_s[0], POWER_ON_REQUEST};
    s_d.pon_prev = s_q.pon_s[1];
    // one-cycle outputs drop by default
    s_d.pu_start = 1'b0;
    s_d.pu_abort = 1'b0;
    s_d.pd_start = 1'b0;
    s_d.ov_irq = 1'b0;

    // overvoltage debounce, restarts on any low sample
    if (!s_q.ov_en || !s_q.ov_s[1])
    begin
      s_d.dbnc_cnt = 20'h0;
      s_d.ov_det = 1'b0;
    end
    else if (!s_q.ov_det)
    begin
      if (s_q.dbnc_cnt + 20'h1 >= dbnc_len(s_q.dbnc))
      begin
        s_d.ov_det = 1'b1;
        ov_evt = 1'b1;
      end
      else
      begin
        s_d.dbnc_cnt = s_q.dbnc_cnt + 20'h1;
      end
    end

    // overvoltage with interrupt reaction, in any powered state
    if (ov_evt && !s_q.ov_sdwn && (s_q.st != ST_UNPWR))
      s_d.ov_irq = 1'b1;

    // power-on event: level or falling edge, same latency either way
    pon_evt = s_q.edge_mode ? (s_q.pon_prev && !s_q.pon_s[1]) : s_q.pon_s[1];
    if (s_q.ov_det && s_q.ov_sdwn)
      pon_evt = 1'b0;

    // host writes in the data phase, honoured only in system-on
    host_wr = s_q.ap_wr && (s_q.st == ST_ON);
    if (host_wr)
    begin
      case (s_q.ap_addr)
        `OFS_FLAGS: s_d.flags = s_q.flags & ~HWDATA[3:0];
        `OFS_COUNT: s_d.failsafe_event_count = `RST_COUNT;
        `OFS_CONFIG:
        begin
          s_d.fs_lim = HWDATA[`CFG_LIMIT_LSB +: 4];
          s_d.decay_sel = HWDATA[`CFG_DECAY_LSB +: 3];
          s_d.ov_en = HWDATA[`CFG_OVEN_BIT];
          s_d.ov_sdwn = HWDATA[`CFG_OVSD_BIT];
          s_d.dbnc = HWDATA[`CFG_DBNC_LSB +: 2];
        end
        default: s_d.fs_lim = s_q.fs_lim;
      endcase
    end

    // decay of the fail-safe count, stops at zero
    if (decay_tick && (s_q.st == ST_ON) && (s_q.failsafe_event_count != 4'h0) && !(host_wr && s_q.ap_addr == `OFS_COUNT))
      s_d.failsafe_event_count = s_q.failsafe_event_count - 4'h1;

    // main power state machine; flag sets come after the host clear so they win
    case (s_q.st)
      ST_UNPWR:
      begin
        if (s_q.uv_s[1])
          s_d.st = ST_LOAD;
      end
      ST_LOAD:
      begin
        // mirror the fuses once per threshold crossing
        s_d.fs_lim = FUSE_LIMIT;
        s_d.bypass = FUSE_BYPASS;
        s_d.decay_sel = FUSE_DECAY;
        s_d.ov_en = FUSE_OV_MONITOR;
        s_d.ov_sdwn = FUSE_OV_SHUTDOWN;
        s_d.dbnc = FUSE_OV_DEBOUNCE;
        s_d.edge_mode = FUSE_EDGE_SELECT;
        s_d.failsafe_event_count = `RST_COUNT;
        s_d.flags = `RST_FLAGS;
        s_d.retain_on = 1'b1;
        s_d.st = ST_OFF;
      end
      ST_OFF:
      begin
        if (pon_evt)
        begin
          s_d.pu_start = 1'b1;
          s_d.regs_permit = 1'b1;
          s_d.fault = 1'b0;
          s_d.st = ST_PWRUP;
        end
      end
      ST_PWRUP:
      begin
        if (POWERUP_FAIL_FLAG_EVENT || THERMAL_EVENT || REG_FAIL_EVENT || WD_MAXED_EVENT)
        begin
          s_d.flags[`FLG_POWERUP] = s_q.flags[`FLG_POWERUP] | POWERUP_FAIL_FLAG_EVENT;
          s_d.flags[`FLG_THERMAL] = s_q.flags[`FLG_THERMAL] | THERMAL_EVENT;
          s_d.flags[`FLG_REGULATOR] = s_q.flags[`FLG_REGULATOR] | REG_FAIL_EVENT;
          s_d.flags[`FLG_WATCHDOG] = s_q.flags[`FLG_WATCHDOG] | WD_MAXED_EVENT;
          s_d.fault = 1'b1;
          s_d.pu_abort = 1'b1;
          s_d.pd_start = 1'b1;
          s_d.regs_permit = 1'b0;
          s_d.st = ST_PWRDN;
        end
        else if (ov_evt && s_q.ov_sdwn)
        begin
          s_d.pu_abort = 1'b1;
          s_d.pd_start = 1'b1;
          s_d.regs_permit = 1'b0;
          s_d.st = ST_PWRDN;
        end
        else if (PU_SEQ_DONE)
        begin
          s_d.st = ST_ON;
        end
      end
      ST_ON:
      begin
        if (THERMAL_EVENT || REG_FAIL_EVENT || WD_MAXED_EVENT)
        begin
          s_d.flags[`FLG_THERMAL] = s_d.flags[`FLG_THERMAL] | THERMAL_EVENT;
          s_d.flags[`FLG_REGULATOR] = s_d.flags[`FLG_REGULATOR] | REG_FAIL_EVENT;
          s_d.flags[`FLG_WATCHDOG] = s_d.flags[`FLG_WATCHDOG] | WD_MAXED_EVENT;
          s_d.fault = 1'b1;
          s_d.pd_start = 1'b1;
          s_d.regs_permit = 1'b0;
          s_d.st = ST_PWRDN;
        end
        else if (OFF_REQUEST || (ov_evt && s_q.ov_sdwn))
        begin
          s_d.pd_start = 1'b1;
          s_d.regs_permit = 1'b0;
          s_d.st = ST_PWRDN;
        end
      end
      ST_PWRDN:
      begin
        // regulators other than retention go down in programmed order
        if (PD_SEQ_DONE)
          s_d.st = s_q.fault ? ST_FSTRANS : ST_OFF;
      end
      ST_FSTRANS:
      begin
        // compare first, so without bypass a zero limit locks on the first fault
        if (!s_q.bypass && (s_q.failsafe_event_count == s_q.fs_lim))
        begin
          s_d.st = ST_LOCK;
        end
        else
        begin
          if (s_q.failsafe_event_count != `COUNT_MAX)
            s_d.failsafe_event_count = s_q.failsafe_event_count + 4'h1;
          s_d.st = ST_OFF;
        end
      end
      ST_LOCK:
      begin
        s_d.st = ST_LOCK;
      end
      default:
      begin
        s_d.st = ST_UNPWR;
      end
    endcase

    // input falling below threshold clears state, flags, count and outputs; flags only survive above it
    if (!s_q.uv_s[1])
    begin
      s_d.st = ST_UNPWR;
      s_d.flags = `RST_FLAGS;
      s_d.failsafe_event_count = `RST_COUNT;
      s_d.fault = 1'b0;
      s_d.regs_permit = 1'b0;
      s_d.retain_on = 1'b0;
      s_d.pu_start = 1'b0;
      s_d.pd_start = 1'b0;
      s_d.pu_abort = 1'b0;
      s_d.ov_irq = 1'b0;
    end

    // bus address phase: latch write intent, register read data for the data phase
    s_d.ap_wr = 1'b0;
    if (HSEL && HTRANS[1] && HREADY)
    begin
      s_d.ap_wr = HWRITE;
      s_d.ap_addr = HADDR[7:0];
      case (HADDR[7:0])
        `OFS_STATUS: s_d.rdata = {22'h0, s_q.retain_on, s_q.ov_det, 8'(s_q.st)};
        `OFS_FLAGS: s_d.rdata = {28'h0, s_q.flags};
        `OFS_COUNT: s_d.rdata = {28'h0, s_q.failsafe_event_count};
        `OFS_CONFIG: s_d.rdata = {20'h0, s_q.dbnc, s_q.ov_sdwn, s_q.ov_en, s_q.decay_sel, s_q.bypass, s_q.fs_lim};
        default: s_d.rdata = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      s_q <= '0;
      s_q.st <= ST_UNPWR;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops; zero wait states, always okay
  assign PU_SEQ_START = s_q.pu_start;
  assign PU_SEQ_ABORT = s_q.pu_abort;
  assign PD_SEQ_START = s_q.pd_start;
  assign REGS_PERMIT = s_q.regs_permit;
  assign RETENTION_ON = s_q.retain_on;
  assign OV_INTERRUPT = s_q.ov_irq;
  assign STATE = s_q.st;
  assign HRDATA = s_q.rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  sequence s_uv_rise_level;
    s_q.st == ST_UNPWR && s_q.uv_s[1] && !FUSE_EDGE_SELECT && s_q.pon_s[1] && !FUSE_OV_SHUTDOWN;
  endsequence

  sequence s_pu_started;
    s_q.pu_start && s_q.st == ST_PWRUP;
  endsequence

  a_startup_bound: assert property (s_uv_rise_level ##1 (s_q.pon_s[1] && s_q.uv_s[1]) [*2] |-> ##1 s_pu_started)
    else $error("power-up did not start after threshold crossing");
  a_pd_clean: assert property (s_q.st == ST_PWRDN && PD_SEQ_DONE && !s_q.fault && s_q.uv_s[1] |=> s_q.st == ST_OFF)
    else $error("clean power-down did not reach off");
  a_pd_fault: assert property (s_q.st == ST_PWRDN && PD_SEQ_DONE && s_q.fault && s_q.uv_s[1] |=> s_q.st == ST_FSTRANS)
    else $error("fault power-down did not reach fail-safe transition");
  a_lock_entry: assert property (s_q.st == ST_FSTRANS && !s_q.bypass && s_q.failsafe_event_count == s_q.fs_lim && s_q.uv_s[1]
    |=> s_q.st == ST_LOCK && $stable(s_q.failsafe_event_count))
    else $error("count at limit did not lock down");
  a_bypass_off: assert property (s_q.st == ST_FSTRANS && s_q.bypass && s_q.uv_s[1] |=> s_q.st == ST_OFF)
    else $error("bypass did not return to off");
  a_count_incr: assert property (s_q.st == ST_FSTRANS && s_q.failsafe_event_count != s_q.fs_lim && s_q.failsafe_event_count != 4'hf && s_q.uv_s[1]
    |=> s_q.failsafe_event_count == $past(s_q.failsafe_event_count) + 4'h1)
    else $error("fail-safe count not incremented");
  a_lock_hold: assert property (s_q.st == ST_LOCK && s_q.uv_s[1] |=> s_q.st == ST_LOCK && $stable(s_q.failsafe_event_count))
    else $error("lock-down left without power cycle");
  a_ov_irq: assert property (ov_evt && !s_q.ov_sdwn && s_q.uv_s[1] && s_q.st != ST_UNPWR |=> OV_INTERRUPT)
    else $error("overvoltage interrupt missing");
  a_ov_shutdown: assert property (ov_evt && s_q.ov_sdwn && s_q.st == ST_ON && s_q.uv_s[1] |=> PD_SEQ_START && s_q.st == ST_PWRDN)
    else $error("overvoltage shutdown did not start power-down");
  a_decay_step: assert property (decay_tick && s_q.st == ST_ON && s_q.failsafe_event_count != 4'h0 && !host_wr && s_q.uv_s[1]
    |=> s_q.failsafe_event_count == $past(s_q.failsafe_event_count) - 4'h1)
    else $error("fail-safe count did not decay");
  a_flag_hold: assert property (s_q.uv_s[1] && !host_wr && s_q.st != ST_LOAD |=> (s_q.flags & $past(s_q.flags)) == $past(s_q.flags))
    else $error("failure flag lost while powered");

endmodule
`default_nettype wire

// [testbench/seq_partner.sv]
// Purpose: sequencer model that answers start pulses with done pulses
// Assumes: same clock as the block
// Notes: delay is set by the bench; abort or a power-down start drops a pending power-up
`timescale 1ns/1ns
`default_nettype none
module seq_partner
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pu_start,
  input wire logic pu_abort,
  input wire logic pd_start,
  input wire logic [7:0] delay,
  output logic pu_done,
  output logic pd_done
);
  int pu_cnt = 0;
  int pd_cnt = 0;
  // countdowns, zero is idle; a long delay stalls the block in its transition
  always @(posedge clk)
  begin
    pu_cnt <= (pu_cnt > 0) ? pu_cnt - 1 : 0;
    pd_cnt <= (pd_cnt > 0) ? pd_cnt - 1 : 0;
    pu_done <= (pu_cnt == 1);
    pd_done <= (pd_cnt == 1);
    if (pu_start)
      pu_cnt <= delay + 1;
    if (pd_start)
      pd_cnt <= delay + 1;
    if (rst || pu_abort || pd_start)
      pu_cnt <= 0;
    if (rst)
      pd_cnt <= 0;
  end
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// Purpose: self-checking bench of the fail-safe power control
// Assumes: short debounce and minute counts set through parameters
// Notes: bus master waits on hreadyout under a bound; each wait is bounded
`timescale 1ns/1ns
`default_nettype none
`include "failsafe_params.svh"
module testbench import failsafe_pkg::*; ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic uv = 1'b0;
  logic ov = 1'b0;
  logic pwr_req = 1'b1;
  logic off_req = 1'b0;
  logic [3:0] flt = 4'h0;
  logic [3:0] f_limit = 4'h2;
  logic f_bypass = 1'b0;
  logic [2:0] f_decay = 3'h1;
  logic f_ovsd = 1'b0;
  logic [1:0] f_dbnc = 2'h0;
  logic f_ovmon = 1'b1;
  logic f_edge = 1'b0;
  logic hsel = 1'b0;
  logic hresp;
  logic [7:0] seq_delay = 8'h03;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, pu_start, pu_abort, pd_start, regs_permit, retention_on, ov_irq, pu_done, pd_done;
  logic irq, abt;
  logic [7:0] state;
  int failures = 0;
  int n_tests = 0;

  always #5 clk = ~clk;

  // decay select 001 gives 50 cycles with 10 cycles a minute
  failsafe_powerdown_control #(.DBNC0_CYC(4), .DBNC1_CYC(8), .DBNC2_CYC(16), .CYC_PER_MIN(10)) dut (
    .CLK_SYS(clk), .RST(rst), .UV_ABOVE(uv), .OV_COMPARE(ov), .POWER_ON_REQUEST(pwr_req),
    .FUSE_LIMIT(f_limit), .FUSE_BYPASS(f_bypass), .FUSE_DECAY(f_decay), .FUSE_OV_MONITOR(f_ovmon),
    .FUSE_OV_SHUTDOWN(f_ovsd), .FUSE_OV_DEBOUNCE(f_dbnc), .FUSE_EDGE_SELECT(f_edge),
    .OFF_REQUEST(off_req), .POWERUP_FAIL_FLAG_EVENT(flt[0]), .WD_MAXED_EVENT(flt[1]), .REG_FAIL_EVENT(flt[2]),
    .THERMAL_EVENT(flt[3]), .PU_SEQ_DONE(pu_done), .PD_SEQ_DONE(pd_done), .PU_SEQ_START(pu_start),
    .PU_SEQ_ABORT(pu_abort), .PD_SEQ_START(pd_start), .REGS_PERMIT(regs_permit),
    .RETENTION_ON(retention_on), .OV_INTERRUPT(ov_irq), .STATE(state), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp));

  seq_partner partner (.clk(clk), .rst(rst), .pu_start(pu_start), .pu_abort(pu_abort),
    .pd_start(pd_start), .delay(seq_delay), .pu_done(pu_done), .pd_done(pd_done));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one bus phase; hreadyout is sampled at the edge that ends it
  task automatic bus_wait();
    int i;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (hreadyout !== 1'b1 && i < 50);
    check("bus ready", {31'h0, hreadyout}, 32'h1);
    check("bus okay", {31'h0, hresp}, 32'h0);
    if (hreadyout !== 1'b1)
      end_of_test();
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    haddr <= a;
    htrans <= 2'b10;
    hsel <= 1'b1;
    hwrite <= wr;
    bus_wait();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    bus_wait();
    rd = hrdata;
  endtask

  task automatic wait_st(input logic [7:0] exp, input int n);
    int i;
    i = 0;
    while (state !== exp && i < n)
    begin
      @(posedge clk);
      i++;
    end
    check("state", {24'h0, state}, {24'h0, exp});
    if (state !== exp)
      end_of_test();
  endtask

  task automatic hold_st(input logic [7:0] exp, input int n);
    logic bad;
    bad = 1'b0;
    repeat (n)
    begin
      @(posedge clk);
      bad = bad | (state !== exp);
    end
    check("state held", {31'h0, bad}, 32'h0);
  endtask

  // collects the two pulse outputs over a window
  task automatic watch(input int n);
    irq = 1'b0;
    abt = 1'b0;
    repeat (n)
    begin
      @(posedge clk);
      irq = irq | ov_irq;
      abt = abt | pu_abort;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // supply drop and rise with new fuses, then defaults seen in the on state
  task automatic supply(input logic [3:0] lim, input logic byp, input logic sd, input logic [1:0] db);
    @(posedge clk);
    uv <= 1'b0;
    f_limit <= lim;
    f_bypass <= byp;
    f_ovsd <= sd;
    f_dbnc <= db;
    repeat (6) @(posedge clk);
    check("unpowered", {24'h0, state}, {24'h0, ST_UNPWR});
    check("retention", {31'h0, retention_on}, 32'h0);
    uv <= 1'b1;
    wait_st(ST_LOAD, 8);
    wait_st(ST_OFF, 8);
    // edge mode needs a falling request once off is reached
    if (f_edge)
      pwr_req <= 1'b0;
    wait_st(ST_PWRUP, `STARTUP_MAX_CYC);
    wait_st(ST_ON, 300);
    ahb(1'b0, `OFS_CONFIG, 32'h0);
    check("config", rd, {20'h0, db, sd, f_ovmon, f_decay, byp, lim});
    ahb(1'b0, `OFS_FLAGS, 32'h0);
    check("flags", rd, 32'h0);
    ahb(1'b0, `OFS_COUNT, 32'h0);
    check("count", rd, 32'h0);
  endtask

  // one-cycle fault pulse, then the power-down walk to the transition
  task automatic fault(input int b);
    @(posedge clk);
    flt[b] <= 1'b1;
    @(posedge clk);
    flt <= 4'h0;
    wait_st(ST_PWRDN, 10);
    check("regs permit", {31'h0, regs_permit}, 32'h0);
    check("retention on", {31'h0, retention_on}, 32'h1);
    wait_st(ST_FSTRANS, 300);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    hold_st(ST_UNPWR, 10);
    supply(4'h2, 1'b0, 1'b0, 2'h0);
    for (int k = 1; k < 4; k++)
    begin
      fault(k);
      if (k < 3)
      begin
        wait_st(ST_OFF, 4);
        wait_st(ST_ON, 300);
        ahb(1'b0, `OFS_FLAGS, 32'h0);
        check("flags", rd, 32'h1 << k);
        ahb(1'b0, `OFS_COUNT, 32'h0);
        check("count", rd, k);
        ahb(1'b1, `OFS_FLAGS, 32'h1 << k);
        ahb(1'b0, `OFS_FLAGS, 32'h0);
        check("flags clear", rd, 32'h0);
      end
    end
    wait_st(ST_LOCK, 4);
    hold_st(ST_LOCK, 50);
    ahb(1'b0, `OFS_COUNT, 32'h0);
    check("count locked", rd, 32'h2);
    ahb(1'b0, `OFS_FLAGS, 32'h0);
    check("flags locked", rd, 32'h8);
    // second life: clean off, host clear, decay and overvoltage
    supply(4'hf, 1'b0, 1'b0, 2'h0);
    fault(2);
    wait_st(ST_ON, 300);
    pwr_req <= 1'b0;
    off_req <= 1'b1;
    @(posedge clk);
    off_req <= 1'b0;
    wait_st(ST_PWRDN, 10);
    wait_st(ST_OFF, 300);
    ahb(1'b1, `OFS_COUNT, 32'h0);
    ahb(1'b0, `OFS_COUNT, 32'h0);
    check("count off", rd, 32'h1);
    ahb(1'b0, `OFS_FLAGS, 32'h0);
    check("flags off", rd, 32'h4);
    pwr_req <= 1'b1;
    wait_st(ST_ON, 300);
    ahb(1'b1, `OFS_COUNT, 32'h0);
    ahb(1'b0, `OFS_COUNT, 32'h0);
    check("count cleared", rd, 32'h0);
    fault(2);
    wait_st(ST_ON, 300);
    ahb(1'b0, `OFS_COUNT, 32'h0);
    check("count", rd, 32'h1);
    // five minutes are 50 cycles: still one at 36, zero after 51
    repeat (30) @(posedge clk);
    ahb(1'b0, `OFS_COUNT, 32'h0);
    check("count held", rd, 32'h1);
    repeat (40) @(posedge clk);
    ahb(1'b0, `OFS_COUNT, 32'h0);
    check("count decayed", rd, 32'h0);
    @(posedge clk);
    ov <= 1'b1;
    @(posedge clk);
    ov <= 1'b0;
    watch(20);
    check("ov glitch", {31'h0, irq}, 32'h0);
    ov <= 1'b1;
    watch(30);
    check("ov irq", {31'h0, irq}, 32'h1);
    check("ov stays on", {24'h0, state}, {24'h0, ST_ON});
    ov <= 1'b0;
    ahb(1'b1, `OFS_CONFIG, 32'h32f);
    ahb(1'b0, `OFS_CONFIG, 32'h0);
    check("config write", rd, 32'h32f);
    ov <= 1'b1;
    wait_st(ST_PWRDN, 40);
    wait_st(ST_OFF, 300);
    hold_st(ST_OFF, 20);
    ov <= 1'b0;
    // third life: bypass with zero limit, power-up failure and abort
    supply(4'h0, 1'b1, 1'b1, 2'h1);
    seq_delay <= 8'd200;
    fault(3);
    wait_st(ST_OFF, 4);
    wait_st(ST_PWRUP, 20);
    fault(0);
    wait_st(ST_OFF, 4);
    ahb(1'b0, `OFS_FLAGS, 32'h0);
    check("flags pu", rd, 32'h9);
    wait_st(ST_PWRUP, 20);
    ov <= 1'b1;
    watch(40);
    check("abort", {31'h0, abt}, 32'h1);
    wait_st(ST_OFF, 300);
    // fourth life: falling-edge power-on, monitor fuse off, zero limit locks
    seq_delay <= 8'h03;
    f_edge <= 1'b1;
    f_ovmon <= 1'b0;
    supply(4'h0, 1'b0, 1'b0, 2'h3);
    watch(30);
    check("ov masked", {31'h0, irq}, 32'h0);
    ov <= 1'b0;
    fault(1);
    wait_st(ST_LOCK, 4);
    end_of_test();
  end

  // hang guard
  initial
  begin
    #900000;
    failures++;
    $display("CHECK FAILED run time expected end seen timeout");
    end_of_test();
  end
endmodule
`default_nettype wire
